// ==== hw/rfbi_consts.svh ====
// Purpose: Constants for the ROM and flash bus interface.
// Assumes: Included by the interface and timer modules.
// Notes: Cycle counts except RFBI_SYNC_LAT are memory clock cycles before doubling.
`ifndef RFBI_CONSTS_SVH
`define RFBI_CONSTS_SVH
`define RFBI_ROM_LAST 32'h01FFFFFF
`define RFBI_BANK_BIT 24
`define RFBI_CFG_WEN 7
`define RFBI_CFG_W16 6
`define RFBI_CFG_FULL 5
`define RFBI_CFG_RESET 8'h40
`define RFBI_NSEQ_SLOW 4'h7
`define RFBI_WR_MIN 4'h3
`define RFBI_BURST_BASE 4'h5
`define RFBI_SYNC_LAT 5'h2
`endif

// ==== hw/rfbi_pkg.sv ====
// Purpose: Types for the ROM and flash bus interface.
// Assumes: Nothing.
// Notes: Holds the bank configuration layout.
package rfbi_pkg;
  typedef struct packed {
    logic wen;
    logic w16;
    logic full;
    logic [1:0] burst;
    logic [2:0] nseq;
  } rfbi_cfg_t;
  typedef struct packed {
    logic req;
    logic wr;
    logic seq;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rfbi_req_t;
  typedef enum logic [1:0] {
    RFBI_IDLE = 2'b00,
    RFBI_ACC = 2'b01,
    RFBI_DONE = 2'b10
  } rfbi_state_t;
endpackage

// ==== hw/rfbi_rom_if.sv ====
// Purpose: ROM and flash bus interface toward the processor.
// Assumes: Processor holds its request until ack; board pins sync.
// Notes: Configuration bytes are plain ports written by cfg strobes.
`timescale 1ns/1ps
`include "rfbi_consts.svh"
module rfbi_rom_if
  import rfbi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire rfbi_req_t cpu_req,
  output logic cpu_ack,
  output logic [31:0] cpu_rdata,
  input wire logic cfg0_we,
  input wire logic cfg1_we,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] rom_bank0_config,
  output logic [7:0] rom_bank1_config,
  output logic rom_chip_select_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic [28:0] latched_address,
  output logic [31:0] data_out,
  output logic data_oe,
  input wire logic [31:0] data_in
);
  rfbi_state_t st_q, st_d;
  logic [7:0] cfg0_q, cfg0_d, cfg1_q, cfg1_d;
  logic [28:0] la_q, la_d;
  logic [15:0] low_q, low_d;
  logic [31:0] rd_q, rd_d;
  logic [31:0] din_s1_q, din_s2_q;
  logic half_q, half_d, brst_q, brst_d, wr_q, wr_d;
  logic cs_q, cs_d, oe_q, oe_d, we_q, we_d, doe_q, doe_d;
  logic ack_q, ack_d, start, done, in_rom, same_grp;
  rfbi_cfg_t cfg;

  function automatic logic [7:0] bank_cfg(input logic [31:0] a,
                                          input logic [7:0] c0,
                                          input logic [7:0] c1);
    bank_cfg = a[`RFBI_BANK_BIT] ? c1 : c0;
  endfunction

  assign in_rom = (cpu_req.addr <= `RFBI_ROM_LAST);
  assign cfg = rfbi_cfg_t'(bank_cfg(cpu_req.addr, cfg0_q, cfg1_q));
  assign same_grp = (la_q[28:4] == cpu_req.addr[28:4]) && cfg.burst != 2'b00;

  rfbi_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .start(start),
    .burst_cyc(brst_d),
    .wr(wr_d),
    .cfg(cfg),
    .done(done)
  );

  always_comb begin
    cfg0_d = cfg0_we ? cfg_wdata : cfg0_q;
    cfg1_d = cfg1_we ? cfg_wdata : cfg1_q;
    st_d = st_q;
    la_d = la_q;
    low_d = low_q;
    rd_d = rd_q;
    half_d = half_q;
    brst_d = brst_q;
    wr_d = wr_q;
    cs_d = cs_q;
    oe_d = oe_q;
    we_d = we_q;
    doe_d = doe_q;
    ack_d = 1'b0;
    start = 1'b0;
    case (st_q)
      RFBI_IDLE: begin
        if (cpu_req.req && in_rom && !ack_q) begin
          wr_d = cpu_req.wr;
          half_d = 1'b0;
          if (cpu_req.wr && !cfg.wen) begin
            ack_d = 1'b1;
          end else begin
            brst_d = cpu_req.seq && same_grp && !cfg.w16;
            if (cfg.w16) begin
              la_d = {cpu_req.addr[27:2], 1'b0, 2'b00};
            end else begin
              la_d = cpu_req.addr[28:0];
            end
            cs_d = 1'b1;
            oe_d = !cpu_req.wr;
            we_d = cpu_req.wr;
            doe_d = cpu_req.wr;
            start = 1'b1;
            st_d = RFBI_ACC;
          end
        end
      end
      RFBI_ACC: begin
        if (done) begin
          we_d = 1'b0;
          if (cfg.w16 && !half_q) begin
            low_d = din_s2_q[15:0];
            half_d = 1'b1;
            brst_d = (cfg.burst != 2'b00);
            la_d = {la_q[28:3], 1'b1, la_q[1:0]};
            we_d = wr_q;
            start = 1'b1;
          end else begin
            rd_d = cfg.w16 ? {din_s2_q[15:0], low_q} : din_s2_q;
            cs_d = 1'b0;
            oe_d = 1'b0;
            doe_d = 1'b0;
            ack_d = 1'b1;
            st_d = RFBI_DONE;
          end
        end
      end
      RFBI_DONE: begin
        st_d = RFBI_IDLE;
      end
      default: begin
        st_d = RFBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RFBI_IDLE;
      cfg0_q <= `RFBI_CFG_RESET;
      cfg1_q <= `RFBI_CFG_RESET;
      la_q <= 29'h0;
      low_q <= 16'h0;
      rd_q <= 32'h0;
      din_s1_q <= 32'h0;
      din_s2_q <= 32'h0;
      half_q <= 1'b0;
      brst_q <= 1'b0;
      wr_q <= 1'b0;
      cs_q <= 1'b0;
      oe_q <= 1'b0;
      we_q <= 1'b0;
      doe_q <= 1'b0;
      ack_q <= 1'b0;
      data_out <= 32'h0;
    end else begin
      st_q <= st_d;
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      la_q <= la_d;
      low_q <= low_d;
      rd_q <= rd_d;
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
      half_q <= half_d;
      brst_q <= brst_d;
      wr_q <= wr_d;
      cs_q <= cs_d;
      oe_q <= oe_d;
      we_q <= we_d;
      doe_q <= doe_d;
      ack_q <= ack_d;
      if (start && wr_d) begin
        data_out <= (cfg.w16 && half_d) ? {16'h0, cpu_req.wdata[31:16]}
                                        : cpu_req.wdata;
      end
    end
  end

  assign cpu_ack = ack_q;
  assign cpu_rdata = rd_q;
  assign rom_bank0_config = cfg0_q;
  assign rom_bank1_config = cfg1_q;
  assign rom_chip_select_n = !cs_q;
  assign output_enable_n = !oe_q;
  assign write_enable_n = !we_q;
  assign latched_address = la_q;
  assign data_oe = doe_q;
endmodule // rfbi_rom_if

// ==== hw/rfbi_timer.sv ====
// Purpose: Computes and counts one ROM cycle length.
// Assumes: Start is a one-cycle pulse, given while idle or on the done cycle for a second halfword.
// Notes: Done pulses on the last cycle of the access.
`timescale 1ns/1ps
`include "rfbi_consts.svh"
module rfbi_timer
  import rfbi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic burst_cyc,
  input wire logic wr,
  input wire rfbi_cfg_t cfg,
  output logic done
);
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] base;
  logic [4:0] len;
  always_comb begin
    if (burst_cyc) begin
      base = `RFBI_BURST_BASE - {2'b00, cfg.burst};
    end else begin
      base = `RFBI_NSEQ_SLOW - {1'b0, cfg.nseq};
    end
    if (wr && base < `RFBI_WR_MIN) begin
      base = `RFBI_WR_MIN;
    end
    len = cfg.full ? {1'b0, base} : {base, 1'b0};
    // Done must not depend on start, or the restart of a second halfword
    // would loop back through the caller's start logic.
    done = (cnt_q == 5'h1);
    cnt_d = cnt_q;
    if (start) begin
      // The extra cycles cover the two-flop delay on the data pins.
      cnt_d = len + `RFBI_SYNC_LAT;
    end else if (cnt_q != 5'h0) begin
      cnt_d = cnt_q - 5'h1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 5'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule // rfbi_timer

// ==== tb/rfbi_chk.sv ====
// Purpose: Assertions on the ROM interface ports.
// Assumes: Requests are held until ack.
// Notes: Exact lengths are checked for 32-bit banks only.
`timescale 1ns/1ps
module rfbi_chk
  import rfbi_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire rfbi_req_t cpu_req,
  input wire logic cpu_ack,
  input wire logic [7:0] rom_bank0_config,
  input wire logic [7:0] rom_bank1_config,
  input wire logic rom_chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [28:0] latched_address,
  input wire logic data_oe
);
  rfbi_cfg_t c;
  logic [3:0] b, n, e;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] pa_q, pa_d;
  logic grp, rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  assign c = rfbi_cfg_t'(cpu_req.addr[24] ? rom_bank1_config
                                         : rom_bank0_config);
  assign grp = cpu_req.seq && c.burst != 2'h0 &&
               cpu_req.addr[31:4] == pa_q[31:4];
  assign b = grp ? 4'h5 - {2'h0, c.burst} : 4'h7 - {1'h0, c.nseq};
  assign n = (cpu_req.wr && b < 4'h3) ? 4'h3 : b;
  assign e = c.full ? n : n << 1;
  assign rd = !cpu_req.wr;
  always_comb begin
    cnt_d = rom_chip_select_n ? 6'h0 : cnt_q + 6'h1;
    pa_d = cpu_ack ? cpu_req.addr : pa_q;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 6'h0;
      pa_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
      pa_q <= pa_d;
    end
  end
  a_cs_range: assert property (!rom_chip_select_n |->
    cpu_req.addr <= 32'h01FFFFFF) else $error("select out of range");
  a_hi_noack: assert property (cpu_req.req &&
    cpu_req.addr > 32'h01FFFFFF |-> !cpu_ack) else $error("high ack");
  a_wr_gate: assert property (!write_enable_n || data_oe
    |-> c.wen) else $error("write while disabled");
  a_oe_read: assert property (!rom_chip_select_n && rd
    |-> !output_enable_n) else $error("no output enable");
  a_cfg_rst: assert property ($rose(nrst) |->
    rom_bank0_config == 8'h40 && rom_bank1_config == 8'h40)
    else $error("bad reset config");
  a_acc_len: assert property (cpu_ack && !c.w16 &&
    (c.wen || rd) |-> cnt_q == e + 6'h2)
    else $error("bad access length");
  a_wr_min: assert property (cpu_ack && cpu_req.wr && c.wen
    |-> cnt_q >= 6'h5) else $error("write too short");
  a_la_word: assert property ($fell(rom_chip_select_n) &&
    !c.w16 |-> latched_address[23:2] == cpu_req.addr[23:2])
    else $error("bad word address");
  a_la_half: assert property ($fell(rom_chip_select_n) &&
    c.w16 |-> !latched_address[2] &&
    latched_address[23:3] == cpu_req.addr[22:2])
    else $error("bad halfword address");
  cover property (cpu_ack && grp);
  cover property (cpu_ack && c.w16);
  cover property (cpu_ack && cpu_req.wr && c.wen);
endmodule // rfbi_chk
bind rfbi_rom_if rfbi_chk rfbi_chk_inst (.*);

// ==== tb/rfbi_rom_model.sv ====
// Purpose: ROM or flash bank beside the interface.
// Assumes: Reads return an address pattern.
// Notes: The released bus toggles every cycle.
`timescale 1ns/1ps
module rfbi_rom_model (
  input wire logic clk,
  input wire logic rom_chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic [28:0] latched_address,
  input wire logic [31:0] data_out,
  input wire logic data_oe,
  output logic [31:0] data_in,
  output logic [31:0] wr_q
);
  logic [31:0] last_q = 32'h0;
  logic [3:0] bstb_n;
  logic [1:0] bank_cs_n;
  assign bstb_n = {4{write_enable_n}} | ~(4'h1 << latched_address[1:0]);
  assign bank_cs_n = {2{rom_chip_select_n}} | {!latched_address[24],
                                              latched_address[24]};
  assign data_in = (!rom_chip_select_n && !output_enable_n) ?
    {latched_address[15:0], ~latched_address[15:0]} : ~last_q;
  always_ff @(posedge clk) begin
    last_q <= data_in;
    if (!write_enable_n && data_oe) begin
      wr_q <= data_out;
    end
  end
endmodule // rfbi_rom_model

// ==== tb/tb_rfbi_rom_if.sv ====
// Purpose: Self-checking bench for the ROM interface.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Latency counts edges from take to ack.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb_rfbi_rom_if
  import rfbi_pkg::*;
;
  logic clk, nrst, cfg0_we, cfg1_we, cpu_ack, data_oe;
  logic rom_chip_select_n, output_enable_n, write_enable_n;
  logic [7:0] cfg_wdata, rom_bank0_config, rom_bank1_config;
  logic [28:0] latched_address;
  logic [31:0] cpu_rdata, data_out, data_in, wr_q;
  rfbi_req_t cpu_req;
  int error_cnt = 0, checks = 0, lat;
  rfbi_rom_if rfbi_rom_if_inst (.*);
  rfbi_rom_model rfbi_rom_model_inst (.*);
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] w16(input logic [31:0] a);
    return {~{a[14:2], 3'h4}, ~{a[14:2], 3'h0}};
  endfunction
  task automatic cfg(input logic b, input logic [7:0] v);
    cfg_wdata = v;
    cfg0_we = !b;
    cfg1_we = b;
    @(posedge clk); #1;
    cfg0_we = 0;
    cfg1_we = 0;
  endtask
  task automatic acc(input logic w, s, input logic [31:0] a, d);
    cpu_req = '{1'h1, w, s, a, d};
    lat = -1;
    do begin
      @(posedge clk); #1;
      lat++;
    end while (cpu_ack !== 1'h1 && lat < 39);
    @(posedge clk); #1;
    cpu_req.req = 0;
    @(posedge clk); #1;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    summarize;
  end
  initial begin
    {nrst, cfg0_we, cfg1_we, cfg_wdata} = 0;
    cpu_req = '0;
    repeat (12) @(posedge clk);
    #1 nrst = 1;
    `CHK(rom_bank0_config, 8'h40)
    `CHK(rom_bank1_config, 8'h40)
    acc(0, 0, 32'h124, 0);
    `CHK(cpu_rdata, w16(32'h124))
    acc(1, 0, 32'h40, 32'h12345678);
    `CHK(lat, 0)
    $display("test reset and defaults done");
    for (int h = 0; h < 2; h++) begin
      for (int i = 0; i < 6; i++) begin
        logic [15:0] x;
        x = 16'(16'h200 + 16 * i);
        cfg(0, {2'h0, h[0], 2'h0, i[2:0]});
        acc(0, 0, 32'h200 + 16 * i, 0);
        `CHK(lat, ((7 - i) << (1 - h)) + 2)
        `CHK(cpu_rdata, {x, ~x})
      end
    end
    $display("test non-sequential timing done");
    for (int b = 1; b < 4; b++) begin
      cfg(0, {3'h1, b[1:0], 3'h5});
      acc(0, 0, 32'h408 + 32'h40 * b, 0);
      acc(0, 1, 32'h40C + 32'h40 * b, 0);
      `CHK(lat, 7 - b)
      `CHK(cpu_rdata[31:16], 16'h40C + 16'h40 * b)
      acc(0, 1, 32'h410 + 32'h40 * b, 0);
      `CHK(lat, 4)
    end
    $display("test burst done");
    cfg(0, 8'hA5);
    acc(1, 0, 32'h80, 32'hCAFE1234);
    `CHK(lat, 5)
    `CHK(wr_q, 32'hCAFE1234)
    cfg(1, 8'h7D);
    acc(0, 0, 32'h01000020, 0);
    `CHK(cpu_rdata, w16(32'h01000020))
    acc(0, 0, 32'h02000000, 0);
    `CHK(lat, 39)
    $display("test write, banks and range done");
    summarize;
  end
endmodule // tb_rfbi_rom_if
